// ===== tsp_defines.vh
// constants for the temperature sensor serial register port
`ifndef TSP_DEFINES_VH
`define TSP_DEFINES_VH
`define TSP_ADDR_PREFIX      4'H9
`define TSP_ADDR_LOW_A       3'H1
`define TSP_ADDR_HIGH_A      3'H3
`define TSP_ADDR_LOW_B       3'H0
`define TSP_ADDR_HIGH_B      3'H2
`define TSP_PTR_TEMP         3'H0
`define TSP_PTR_CONFIG       3'H1
`define TSP_PTR_HYST         3'H2
`define TSP_PTR_OTLIM        3'H3
`define TSP_PTR_ONESHOT      3'H4
`define TSP_PTR_RESET        8'H00
`define TSP_CONFIG_RESET     8'H00
`define TSP_HYST_RESET       16'H4B00
`define TSP_OTLIM_RESET      16'H5000
`define TSP_CFG_POL_BIT      2
`define TSP_CFG_INT_BIT      1
`define TSP_TIMEOUT_MS       25
`define TSP_CLK_HZ           10000000
`define TSP_TIMEOUT_CYCLES   ((`TSP_TIMEOUT_MS * `TSP_CLK_HZ) / 1000)
`endif

// ===== tsp_port.v
// two-wire target port with pointer-selected sensor registers
//
// Overview of operation
// R1: alert becomes active when temperature reaches the over-temperature limit
// R2: limits are two's complement; upper byte returned first, then lower byte
// R3: over-temperature limit resets to +80 degrees, 0x5000
// R4: device is only a target; the master starts every transfer
// R5: target address is 1001 prefix plus bits set by select pin
// R6: variant A answers 0x49 with select low, 0x4B with select high
// R7: variant B answers 0x48 with select low, 0x4A with select high
// R8: 25 ms without data line activity abandons transfer, releases data line
// R9: master opens each transfer with data falling while clock high
// R10: after start, shift seven address bits msb first, then direction bit
// R11: matching address acknowledged low in ninth slot, else idle until start
// R12: each byte is eight bits plus acknowledge from the receiver
// R13: data changes only while clock low; rise during clock high is stop
// R14: master ends a write with a stop condition
// R15: master ends a read with not-acknowledge then a stop
// R16: direction is fixed by address byte; changing needs a new transfer
// R17: first written byte after address loads the register pointer
// R18: configuration write carries pointer byte then one data byte
// R19: limit register write carries pointer byte then two data bytes
// R20: configuration read returns a single byte
// R21: temperature read returns two bytes, most significant first
// R22: reads return the pointed register; pointer holds between transfers
// R23: low three pointer bits select register; pointer resets to zero
// R24: in interrupt mode any completed read clears the active alert; code clears it only while temperature is below the over-temperature limit
// R25: every received byte after a matching address is acknowledged
// R26: keep sending while master acknowledges; release after not-acknowledge
`include "tsp_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module tsp_port #(
    parameter         VARIANT_B      = 0,
    parameter [31:0]  TIMEOUT_CYCLES = `TSP_TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        clk_en_i,
    // two-wire bus pins
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_o,
    // address select strap
    input  wire        address_select_pin_i,
    // measurement side
    input  wire [15:0] temp_value_i,
    output reg         overtemp_alert_output_o,
    output reg         oneshot_start_o,
    output reg  [7:0]  config_o
);
    localparam ST_IDLE = 3'H0;
    localparam ST_ADDR = 3'H1;
    localparam ST_AACK = 3'H2;
    localparam ST_WR   = 3'H3;
    localparam ST_WACK = 3'H4;
    localparam ST_RD   = 3'H5;
    localparam ST_RACK = 3'H6;

    reg  [2:0]  scl_s_q;
    reg  [2:0]  sda_s_q;
    reg  [1:0]  sel_s_q;
    reg  [2:0]  state_q;
    reg  [3:0]  bit_cnt_q;
    reg  [7:0]  shift_q;
    reg  [1:0]  byte_cnt_q;
    reg  [7:0]  ptr_q;
    reg  [15:0] hyst_q;
    reg  [15:0] otlim_q;
    reg  [7:0]  wr_hi_q;
    reg  [31:0] idle_cnt_q;
    reg         alert_q;
    reg         rd_done_q;

    wire scl_v   = scl_s_q[1];
    wire sda_v   = sda_s_q[1];
    wire scl_r   = scl_s_q[1] & ~scl_s_q[2];
    wire scl_f   = ~scl_s_q[1] & scl_s_q[2];
    // start and stop detection
    wire start_c = scl_v & scl_s_q[2] & ~sda_v & sda_s_q[2];
    wire stop_c  = scl_v & scl_s_q[2] & sda_v & ~sda_s_q[2];
    wire sda_chg = sda_v ^ sda_s_q[2];
    wire bus_tmo = (state_q != ST_IDLE) && (idle_cnt_q >= TIMEOUT_CYCLES - 32'H1);

    // own address from prefix and strap
    // R6: variant A address pair
    wire [2:0] addr_lo_a = sel_s_q[1] ? `TSP_ADDR_HIGH_A : `TSP_ADDR_LOW_A;
    // R7: variant B address pair
    wire [2:0] addr_lo_b = sel_s_q[1] ? `TSP_ADDR_HIGH_B : `TSP_ADDR_LOW_B;
    wire [2:0] addr_lo   = (VARIANT_B != 0) ? addr_lo_b : addr_lo_a;
    wire [6:0] own_addr  = {`TSP_ADDR_PREFIX, addr_lo};
    wire       addr_hit  = (shift_q[7:1] == own_addr);

    // register selected by pointer
    function [15:0] sel_reg;
        input [2:0] p;
        begin
            case (p)
                `TSP_PTR_TEMP:   sel_reg = temp_value_i;
                `TSP_PTR_CONFIG: sel_reg = {config_o, config_o};
                `TSP_PTR_HYST:   sel_reg = hyst_q;
                `TSP_PTR_OTLIM:  sel_reg = otlim_q;
                default:         sel_reg = 16'H0000;
            endcase
        end
    endfunction

    // signed compare of two temperature words
    function at_or_above;
        input [15:0] a;
        input [15:0] b;
        begin
            at_or_above = ($signed(a) >= $signed(b));
        end
    endfunction

    wire [15:0] rd_word = sel_reg(ptr_q[2:0]);
    wire [7:0]  rd_byte = (byte_cnt_q[0] && ptr_q[2:0] != `TSP_PTR_CONFIG) ? rd_word[7:0] : rd_word[15:8];
    wire [7:0]  rx_byte = {shift_q[6:0], sda_v};

    // pin synchronisers
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_s_q <= 3'H7;
            sda_s_q <= 3'H7;
            sel_s_q <= 2'H0;
        end else if (clk_en_i) begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
            sel_s_q <= {sel_s_q[0], address_select_pin_i};
        end
    end

    // alert flag and pin level
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            alert_q <= 1'B0;
            overtemp_alert_output_o <= 1'B1;
        end else if (clk_en_i) begin
            // R1: alert at or above limit
            if (at_or_above(temp_value_i, otlim_q)) begin
                alert_q <= 1'B1;
            // R24: read clears interrupt
            end else if (config_o[`TSP_CFG_INT_BIT] && rd_done_q) begin
                alert_q <= 1'B0;
            end else if (!config_o[`TSP_CFG_INT_BIT] && !at_or_above(temp_value_i, hyst_q)) begin
                alert_q <= 1'B0;
            end
            overtemp_alert_output_o <= config_o[`TSP_CFG_POL_BIT] ? alert_q : ~alert_q;
        end
    end

    // R8: bus timeout counter
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            idle_cnt_q <= 32'H0;
        end else if (clk_en_i) begin
            if (state_q == ST_IDLE || sda_chg)
                idle_cnt_q <= 32'H0;
            else
                idle_cnt_q <= idle_cnt_q + 32'H1;
        end
    end

    // transfer state machine and registers
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'H0;
            shift_q <= 8'H00;
            byte_cnt_q <= 2'H0;
            // pointer reset value
            // R23: pointer reset
            ptr_q <= `TSP_PTR_RESET;
            config_o <= `TSP_CONFIG_RESET;
            hyst_q <= `TSP_HYST_RESET;
            // R3: limit power-up value
            otlim_q <= `TSP_OTLIM_RESET;
            wr_hi_q <= 8'H00;
            rd_done_q <= 1'B0;
            sda_o <= 1'B0;
            sda_oe_o <= 1'B0;
            oneshot_start_o <= 1'B0;
        end else if (clk_en_i) begin
            // R4: target only, never drives high
            sda_o <= 1'B0;
            oneshot_start_o <= 1'B0;
            rd_done_q <= 1'B0;
            // R8: abandon on timeout
            if (bus_tmo) begin
                state_q <= ST_IDLE;
                sda_oe_o <= 1'B0;
            // R9: start restarts framing
            end else if (start_c) begin
                state_q <= ST_ADDR;
                bit_cnt_q <= 4'H0;
                byte_cnt_q <= 2'H0;
                sda_oe_o <= 1'B0;
            // R13: stop ends transfer
            end else if (stop_c) begin
                state_q <= ST_IDLE;
                sda_oe_o <= 1'B0;
            end else begin
                case (state_q)
                    ST_ADDR, ST_WR: begin
                        // R10: shift msb first
                        if (scl_r) begin
                            shift_q <= rx_byte;
                            bit_cnt_q <= bit_cnt_q + 4'H1;
                        end
                        if (scl_f && bit_cnt_q == 4'H8) begin
                            bit_cnt_q <= 4'H0;
                            if (state_q == ST_ADDR) begin
                                // R11: acknowledge own address
                                // R5: address compare
                                if (addr_hit) begin
                                    sda_oe_o <= 1'B1;
                                    state_q <= ST_AACK;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else begin
                                // R25: acknowledge each byte
                                sda_oe_o <= 1'B1;
                                state_q <= ST_WACK;
                                // R17: first byte is pointer
                                if (byte_cnt_q == 2'H0) begin
                                    ptr_q <= shift_q;
                                    if (shift_q[2:0] == `TSP_PTR_ONESHOT)
                                        oneshot_start_o <= 1'B1;
                                // R18: single config byte
                                end else if (ptr_q[2:0] == `TSP_PTR_CONFIG && byte_cnt_q == 2'H1) begin
                                    config_o <= shift_q;
                                // R19: two limit bytes
                                end else if (byte_cnt_q == 2'H1) begin
                                    wr_hi_q <= shift_q;
                                end else if (byte_cnt_q == 2'H2) begin
                                    if (ptr_q[2:0] == `TSP_PTR_HYST)
                                        hyst_q <= {wr_hi_q, shift_q};
                                    else if (ptr_q[2:0] == `TSP_PTR_OTLIM)
                                        otlim_q <= {wr_hi_q, shift_q};
                                end
                                if (byte_cnt_q != 2'H3)
                                    byte_cnt_q <= byte_cnt_q + 2'H1;
                            end
                        end
                    end
                    ST_AACK, ST_WACK: begin
                        // R12: ninth pulse ends byte
                        if (scl_f) begin
                            // R16: direction from address byte
                            if (state_q == ST_AACK && shift_q[0]) begin
                                state_q <= ST_RD;
                                // R22: pointed register out
                                shift_q <= rd_byte;
                                sda_oe_o <= ~rd_byte[7];
                                bit_cnt_q <= 4'H1;
                            end else begin
                                sda_oe_o <= 1'B0;
                                state_q <= ST_WR;
                            end
                        end
                    end
                    ST_RD: begin
                        if (scl_f) begin
                            if (bit_cnt_q == 4'H8) begin
                                sda_oe_o <= 1'B0;
                                state_q <= ST_RACK;
                            end else begin
                                // R2: upper byte first
                                // R21: msb sent first
                                sda_oe_o <= ~shift_q[3'H7 - bit_cnt_q[2:0]];
                                bit_cnt_q <= bit_cnt_q + 4'H1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_r) begin
                            // R26: stop on not-acknowledge
                            if (sda_v) begin
                                state_q <= ST_IDLE;
                                rd_done_q <= 1'B1;
                            end else begin
                                byte_cnt_q <= byte_cnt_q ^ 2'H1;
                                rd_done_q <= 1'B1;
                            end
                        end
                        if (scl_f) begin
                            // R20: config repeats same byte
                            shift_q <= rd_byte;
                            sda_oe_o <= ~rd_byte[7];
                            bit_cnt_q <= 4'H1;
                            state_q <= ST_RD;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // tsp_port
`default_nettype wire

// ===== tsp_port_chk.sv
// concurrent checks on the serial register port pins
`timescale 1ns/1ns
`default_nettype none
module tsp_port_chk #(
    parameter [31:0] TIMEOUT_CYCLES = 32'H3D090
) (
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    // bus pins and outputs
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       overtemp_alert_output_o,
    input wire logic       oneshot_start_o,
    input wire logic [7:0] config_o
);
    logic [31:0] quiet_q;
    logic        sda_q;
    // cycles since the data line last moved
    always_ff @(posedge ref_clk_i) begin
        sda_q   <= sda_i;
        quiet_q <= (rst_i || sda_i != sda_q) ? 32'H0 : quiet_q + 32'H1;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    rst_idle_a: assert property ($fell(rst_i) |-> !sda_oe_o && !oneshot_start_o && config_o == 8'H00)
        else $error("port not idle after reset");
    alert_idle_a: assert property ($fell(rst_i) |-> overtemp_alert_output_o)
        else $error("alert active after reset");
    drive_low_a: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("data driven high");
    rise_low_a: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("drive began with clock high");
    hold_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("data moved with clock high");
    shot_pulse_a: assert property (oneshot_start_o |=> !oneshot_start_o)
        else $error("one-shot pulse too long");
    stop_free_a: assert property (scl_i && $rose(sda_i) |-> (!sda_oe_o) [*8])
        else $error("driving after stop");
    tmo_release_a: assert property (quiet_q > TIMEOUT_CYCLES + 32'H10 |-> !sda_oe_o)
        else $error("data line held past timeout");
endmodule // tsp_port_chk
bind tsp_port tsp_port_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .config_o(config_o),
    .overtemp_alert_output_o(overtemp_alert_output_o), .oneshot_start_o(oneshot_start_o));
`default_nettype wire

// ===== tsp_bus_master.sv
// two-wire bus master model facing the port
`timescale 1ns/1ns
`default_nettype none
module tsp_bus_master (
    // clock and bus
    input  wire logic ref_clk_i,
    input  wire logic sda_i,
    output var  logic scl_o = 1'b1,
    output var  logic sda_pull_o = 1'b0
);
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
        #10;
    endtask
    // data moves only while clock low
    task automatic bit_io(input logic b, output logic r);
        sda_pull_o = !b;
        wt(5);
        scl_o = 1'b1;
        wt(8);
        r = sda_i;
        wt(2);
        scl_o = 1'b0;
        wt(5);
    endtask
    task automatic cond(input logic p0, input logic p1, input logic c1);
        sda_pull_o = p0;
        wt(5);
        scl_o = 1'b1;
        wt(5);
        sda_pull_o = p1;
        wt(5);
        scl_o = c1;
        wt(5);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(last, ack);
    endtask
endmodule // tsp_bus_master
`default_nettype wire

// ===== tsp_port_tb.sv
// self-checking bench for the serial register port
`timescale 1ns/1ns
`default_nettype none
module tsp_port_tb;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sel = 1'b0;
    logic [15:0] temp = 16'H1910;
    logic        en = 1'b1;
    logic        scl, pull, oe, oe_b, oe_b_q, sda_o, alert, shot, ack;
    logic [7:0]  cfg, rx;
    int          errors = 0;
    int          check_count = 0;
    int          shots = 0;
    int          b_acks = 0;
    wire         sda = !(oe || oe_b || pull);
    tsp_port #(.TIMEOUT_CYCLES(32'H3E8)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(en),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(oe), .address_select_pin_i(sel),
        .temp_value_i(temp), .overtemp_alert_output_o(alert), .oneshot_start_o(shot), .config_o(cfg));
    tsp_port #(.VARIANT_B(1), .TIMEOUT_CYCLES(32'H3E8)) uut_b (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .clk_en_i(en), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe_b), .address_select_pin_i(sel),
        .temp_value_i(temp), .overtemp_alert_output_o(), .oneshot_start_o(), .config_o());
    tsp_bus_master m (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    always #50 ref_clk_i = !ref_clk_i;
    always @(posedge ref_clk_i) if (shot === 1'b1) shots++;
    always @(posedge ref_clk_i) begin
        oe_b_q <= oe_b;
        if (oe_b === 1'b1 && oe_b_q !== 1'b1) b_acks++;
    end
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic put(input logic [7:0] b);
        m.xfer(b, 1'b1, rx, ack);
        check_val({15'H0, ack}, 16'H0000);
    endtask
    task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
        m.cond(1'b0, 1'b1, 1'b0);
        put({4'H9, 1'b0, sel, 1'b1, 1'b0});
        put(p);
        for (int i = n; i > 0; i--)
            put(d[8*i-1 -: 8]);
        m.cond(1'b1, 1'b0, 1'b1);
    endtask
    task automatic rd(input int n, output logic [23:0] q);
        m.cond(1'b0, 1'b1, 1'b0);
        put({4'H9, 1'b0, sel, 1'b1, 1'b1});
        for (int i = n; i > 0; i--) begin
            m.xfer(8'HFF, i == 1, rx, ack);
            q = {q[15:0], rx};
        end
        m.cond(1'b1, 1'b0, 1'b1);
    endtask
    task automatic sc_reset;
        logic [23:0] q;
        rd(3, q);
        check_val(q[23:8], 16'H1910);
        check_val({8'H0, q[7:0]}, 16'H0019);
        wr(8'H03, 0, 16'H0000);
        rd(2, q);
        check_val(q[15:0] & 16'HFFF0, 16'H5000);
    endtask
    task automatic sc_addr;
        int n0;
        for (int s = 0; s < 2; s++) begin
            sel = s[0];
            for (int a = 8; a < 13; a++) begin
                n0 = b_acks;
                m.cond(1'b0, 1'b1, 1'b0);
                m.xfer({4'H9, a[2:0], 1'b0}, 1'b1, rx, ack);
                m.cond(1'b1, 1'b0, 1'b1);
                check_val({15'H0, ack}, {15'H0, a[2:1] != {1'b0, s[0]}});
                check_val(16'(b_acks - n0), {15'H0, a[2:0] == {1'b0, s[0], 1'b0}});
            end
        end
        sel = 1'b0;
    endtask
    task automatic sc_regs;
        logic [23:0] q;
        wr(8'H01, 1, 16'H0006);
        check_val({8'H0, cfg}, 16'H0006);
        rd(1, q);
        check_val({8'H0, q[7:0]}, 16'H0006);
        wr(8'H02, 2, 16'H4810);
        wr(8'H03, 2, 16'H4C20);
        rd(2, q);
        check_val(q[15:0], 16'H4C20);
        wr(8'H02, 0, 16'H0000);
        rd(2, q);
        check_val(q[15:0], 16'H4810);
    endtask
    task automatic sc_alert;
        logic [23:0] q;
        wr(8'H01, 1, 16'H0000);
        temp = 16'H4C20;
        m.wt(5);
        check_val({15'H0, alert}, 16'H0000);
        temp = 16'H4000;
        wr(8'H01, 1, 16'H0002);
        check_val({15'H0, alert}, 16'H0001);
        temp = 16'H4C20;
        m.wt(5);
        temp = 16'H4000;
        m.wt(5);
        check_val({15'H0, alert}, 16'H0000);
        rd(2, q);
        check_val({15'H0, alert}, 16'H0001);
        check_val(q[15:0], 16'H0202);
        en = 1'b0;
        temp = 16'H4C20;
        m.wt(5);
        check_val({15'H0, alert}, 16'H0001);
        en = 1'b1;
        m.wt(5);
        check_val({15'H0, alert}, 16'H0000);
        wr(8'H01, 1, 16'H0006);
        check_val({15'H0, alert}, 16'H0001);
    endtask
    task automatic sc_shot;
        int n0;
        n0 = shots;
        wr(8'H04, 0, 16'H0000);
        check_val(16'(shots - n0), 16'H0001);
    endtask
    task automatic sc_tmo;
        logic [23:0] q;
        temp = 16'H0000;
        wr(8'H00, 0, 16'H0000);
        m.cond(1'b0, 1'b1, 1'b0);
        put({4'H9, 1'b0, sel, 1'b1, 1'b1});
        m.wt(3);
        check_val({15'H0, oe}, 16'H0001);
        m.wt(1030);
        check_val({15'H0, oe}, 16'H0000);
        temp = 16'H1910;
        m.cond(1'b1, 1'b0, 1'b1);
        rd(2, q);
        check_val(q[15:0], 16'H1910);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        #10;
        rst_i = 1'b0;
        m.wt(3);
        sc_reset();
        sc_addr();
        sc_regs();
        sc_alert();
        sc_shot();
        sc_tmo();
        close_out();
    end
    initial begin
        #5000000;
        errors++;
        close_out();
    end
endmodule // tsp_port_tb
`default_nettype wire
